// ==== rtl/lf_clock_pkg.sv ====
/*
  Constants for the low-frequency clock and calibration controller:
  register byte offsets, field positions, source codes and state codes.
  Assumes a 32-bit classic Wishbone bus with word-aligned registers.
*/
package lf_clock_pkg;
  // ==========================================================
  // Bus geometry
  localparam int ADR_W = 12;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] OFF_HF_START = 12'h000;
  localparam logic [11:0] OFF_HF_STOP = 12'h004;
  localparam logic [11:0] OFF_LF_START = 12'h008;
  localparam logic [11:0] OFF_LF_STOP = 12'h00C;
  localparam logic [11:0] OFF_CAL = 12'h010;
  localparam logic [11:0] OFF_CT_START = 12'h014;
  localparam logic [11:0] OFF_CT_STOP = 12'h018;
  localparam logic [11:0] OFF_EV_HF = 12'h100;
  localparam logic [11:0] OFF_EV_LF = 12'h104;
  localparam logic [11:0] OFF_EV_DONE = 12'h10C;
  localparam logic [11:0] OFF_EV_CAL_TIMER_TIMEOUT_EVENT = 12'h110;
  localparam logic [11:0] OFF_IEN_SET = 12'h304;
  localparam logic [11:0] OFF_IEN_CLR = 12'h308;
  localparam logic [11:0] OFF_HF_RUN = 12'h408;
  localparam logic [11:0] OFF_HF_STAT = 12'h40C;
  localparam logic [11:0] OFF_LF_RUN = 12'h414;
  localparam logic [11:0] OFF_LF_STAT = 12'h418;
  localparam logic [11:0] OFF_LF_COPY = 12'h41C;
  localparam logic [11:0] OFF_LF_SRC = 12'h518;
  localparam logic [11:0] OFF_CAL_TIMER_INTERVAL = 12'h538;
  // ==========================================================
  // Field positions
  localparam int TASK_BIT = 0;
  localparam int SRC_LSB = 0;
  localparam int BYPASS_BIT = 16;
  localparam int EXTERNAL_BIT = 17;
  localparam int STATE_BIT = 16;
  localparam int IEN_HF = 0;
  localparam int IEN_LF = 1;
  localparam int IEN_DONE = 2;
  localparam int IEN_CAL_TIMER_TIMEOUT_EVENT = 3;
  localparam int IEN_W = 4;
  localparam int CAL_TIMER_INTERVAL_W = 7;
  // ==========================================================
  // Source codes and reset values
  localparam logic [1:0] SRC_RC = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_SYNTH = 2'h2;
  localparam logic [31:0] TASK_RESET = 32'h00000000;
  // ==========================================================
  // State machines
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN = 2'b10
  } cal_state_t;
  typedef enum logic [1:0] {
    CT_IDLE = 2'b01,
    CT_RUN = 2'b10
  } ct_state_t;
  typedef struct packed {
    logic [1:0] src;
    logic ext;
    logic byp;
  } src_cfg_t;
endpackage

// ==== rtl/low_freq_clock_calibration_ctrl.sv ====
/*
  Low-frequency clock source control, RC calibration sequencing and
  calibration interval timer, with a classic Wishbone register slave.
  Assumes: lf_tick_i pulses once per low-frequency clock period, the
  oscillators report readiness on the status inputs, one clock domain.
*/
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
module low_freq_clock_calibration_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [lf_clock_pkg::ADR_W-1:2] adr_i,
  input wire logic [lf_clock_pkg::SEL_W-1:0] sel_i,
  input wire logic [lf_clock_pkg::DAT_W-1:0] dat_i,
  output logic [lf_clock_pkg::DAT_W-1:0] dat_o,
  output logic ack_o,
  input wire logic lf_tick_i,
  input wire logic hf_crystal_stable_i,
  input wire logic lf_crystal_running_i,
  input wire logic cal_finish_i,
  output logic hf_crystal_osc_en_o,
  output logic high_freq_clock_req_o,
  output logic lf_rc_osc_en_o,
  output logic lf_crystal_osc_en_o,
  output logic lf_crystal_ext_o,
  output logic lf_crystal_bypass_o,
  output logic lf_synth_source_en_o,
  output logic [1:0] low_freq_clock_mux_o,
  output logic cal_run_o
);
  import lf_clock_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] rdata;
    logic hf_run;
    logic hf_on;
    logic lf_run;
    logic lf_on;
    logic lf_on_xtal;
    src_cfg_t copy;
    src_cfg_t sel;
    logic [IEN_W-1:0] ev;
    logic [IEN_W-1:0] ien;
    cal_state_t cal;
    ct_state_t ct;
    logic [CAL_TIMER_INTERVAL_W-1:0] count;
    logic [CAL_TIMER_INTERVAL_W-1:0] cal_timer_interval;
  } state_t;

  state_t state_reg;
  state_t state_next;

  function automatic logic [DAT_W-1:0] merge(input logic [DAT_W-1:0] old,
      input logic [DAT_W-1:0] nw, input logic [SEL_W-1:0] sel);
    logic [DAT_W-1:0] res;
    res = old;
    for (int b = 0; b < SEL_W; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [DAT_W-1:0] pack_src(input src_cfg_t c);
    logic [DAT_W-1:0] w;
    w = '0;
    w[SRC_LSB +: 2] = c.src;
    w[BYPASS_BIT] = c.byp;
    w[EXTERNAL_BIT] = c.ext;
    return w;
  endfunction

  logic req;
  logic wr;
  logic [ADR_W-1:0] addr;
  logic trig;
  logic [DAT_W-1:0] wsrc;
  logic [DAT_W-1:0] wct;
  logic ct_go;

  // ==========================================================
  // Bus decode
  assign req = cyc_i && stb_i;
  assign wr = req && we_i && state_reg.ack;
  assign addr = {adr_i, 2'b00};
  assign trig = sel_i[0] && dat_i[TASK_BIT];
  assign ct_go = wr && addr == OFF_CT_START && trig;

  always_comb begin
    state_next = state_reg;
    wsrc = merge(pack_src(state_reg.sel), dat_i, sel_i);
    wct = merge({{(DAT_W-CAL_TIMER_INTERVAL_W){1'b0}}, state_reg.cal_timer_interval}, dat_i, sel_i);
    state_next.ack = req && !state_reg.ack;
    state_next.rdata = '0;
    // Register read mux
    case (addr)
      OFF_EV_HF: state_next.rdata[0] = state_reg.ev[IEN_HF];
      OFF_EV_LF: state_next.rdata[0] = state_reg.ev[IEN_LF];
      OFF_EV_DONE: state_next.rdata[0] = state_reg.ev[IEN_DONE];
      OFF_EV_CAL_TIMER_TIMEOUT_EVENT: state_next.rdata[0] = state_reg.ev[IEN_CAL_TIMER_TIMEOUT_EVENT];
      OFF_IEN_SET, OFF_IEN_CLR: begin
        state_next.rdata[IEN_W-1:0] = state_reg.ien;
      end
      OFF_HF_RUN: state_next.rdata[0] = state_reg.hf_run;
      OFF_HF_STAT: begin
        state_next.rdata[0] = state_reg.hf_on;
        state_next.rdata[STATE_BIT] = state_reg.hf_on;
      end
      OFF_LF_RUN: state_next.rdata[0] = state_reg.lf_run;
      OFF_LF_STAT: begin
        state_next.rdata[SRC_LSB +: 2] = low_freq_clock_mux_o;
        state_next.rdata[STATE_BIT] = state_reg.lf_on;
      end
      OFF_LF_COPY: state_next.rdata = pack_src(state_reg.copy);
      OFF_LF_SRC: state_next.rdata = pack_src(state_reg.sel);
      OFF_CAL_TIMER_INTERVAL: state_next.rdata[CAL_TIMER_INTERVAL_W-1:0] = state_reg.cal_timer_interval;
      default: state_next.rdata = '0;
    endcase
    if (!req || we_i || state_reg.ack) begin
      state_next.rdata = state_reg.rdata;
    end
    // ==========================================================
    // Register writes, taken at the acknowledged edge
    if (wr) begin
      case (addr)
        OFF_HF_START: begin
          if (trig) begin
            state_next.hf_run = 1'b1;
          end
        end
        OFF_HF_STOP: begin
          if (trig) begin
            state_next.hf_run = 1'b0;
            state_next.hf_on = 1'b0;
          end
        end
        OFF_LF_START: begin
          if (trig) begin
            state_next.lf_run = 1'b1;
            state_next.copy = state_reg.sel;
            state_next.lf_on = 1'b0;
            state_next.lf_on_xtal = 1'b0;
          end
        end
        OFF_LF_STOP: begin
          if (trig) begin
            state_next.lf_run = 1'b0;
            state_next.lf_on = 1'b0;
            state_next.lf_on_xtal = 1'b0;
          end
        end
        OFF_CAL: begin
          if (trig && state_reg.lf_on && state_reg.copy.src == SRC_RC) begin
            state_next.cal = CAL_RUN;
          end
        end
        OFF_CT_START: begin
          if (trig) begin
            state_next.ct = CT_RUN;
            state_next.count = state_reg.cal_timer_interval;
          end
        end
        OFF_CT_STOP: begin
          if (trig) begin
            state_next.ct = CT_IDLE;
          end
        end
        OFF_EV_HF: if (sel_i[0]) state_next.ev[IEN_HF] = dat_i[0];
        OFF_EV_LF: if (sel_i[0]) state_next.ev[IEN_LF] = dat_i[0];
        OFF_EV_DONE: if (sel_i[0]) state_next.ev[IEN_DONE] = dat_i[0];
        OFF_EV_CAL_TIMER_TIMEOUT_EVENT: if (sel_i[0]) state_next.ev[IEN_CAL_TIMER_TIMEOUT_EVENT] = dat_i[0];
        OFF_IEN_SET: begin
          if (sel_i[0]) begin
            state_next.ien = state_reg.ien | dat_i[IEN_W-1:0];
          end
        end
        OFF_IEN_CLR: begin
          if (sel_i[0]) begin
            state_next.ien = state_reg.ien & ~dat_i[IEN_W-1:0];
          end
        end
        OFF_LF_SRC: begin
          state_next.sel.src = wsrc[SRC_LSB +: 2];
          state_next.sel.byp = wsrc[BYPASS_BIT];
          state_next.sel.ext = wsrc[EXTERNAL_BIT];
        end
        OFF_CAL_TIMER_INTERVAL: state_next.cal_timer_interval = wct[CAL_TIMER_INTERVAL_W-1:0];
        default: state_next.rdata = state_next.rdata;
      endcase
    end
    // ==========================================================
    // Oscillator status; hardware sets win over software clears
    if (state_reg.hf_run && hf_crystal_stable_i && !state_reg.hf_on) begin
      state_next.hf_on = 1'b1;
      state_next.ev[IEN_HF] = 1'b1;
    end
    if (state_reg.lf_run && !state_reg.lf_on) begin
      if (state_reg.copy.src != SRC_XTAL || lf_crystal_running_i) begin
        state_next.lf_on = 1'b1;
        state_next.lf_on_xtal = state_reg.copy.src == SRC_XTAL;
        state_next.ev[IEN_LF] = 1'b1;
      end
    end
    // Calibration sequence
    case (state_reg.cal)
      CAL_IDLE: state_next.cal = state_next.cal;
      CAL_RUN: begin
        if (cal_finish_i) begin
          state_next.cal = CAL_IDLE;
          state_next.ev[IEN_DONE] = 1'b1;
        end
      end
      default: state_next.cal = CAL_IDLE;
    endcase
    // Interval timer, one step per low-frequency period
    case (state_reg.ct)
      CT_IDLE: state_next.ct = state_next.ct;
      CT_RUN: begin
        if (lf_tick_i && state_next.ct == CT_RUN && !ct_go) begin
          if (state_reg.count <= CAL_TIMER_INTERVAL_W'(1)) begin
            state_next.count = '0;
            state_next.ct = CT_IDLE;
            state_next.ev[IEN_CAL_TIMER_TIMEOUT_EVENT] = 1'b1;
          end else begin
            state_next.count = state_reg.count - CAL_TIMER_INTERVAL_W'(1);
          end
        end
      end
      default: state_next.ct = CT_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.sel <= '{src: SRC_RC, ext: 1'b0, byp: 1'b0};
      state_reg.copy <= '{src: SRC_RC, ext: 1'b0, byp: 1'b0};
      state_reg.cal <= CAL_IDLE;
      state_reg.ct <= CT_IDLE;
      state_reg.cal_timer_interval <= state_reg.cal_timer_interval;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign dat_o = state_reg.rdata;
  assign ack_o = state_reg.ack;
  assign cal_run_o = state_reg.cal == CAL_RUN;
  assign hf_crystal_osc_en_o = state_reg.hf_run;
  assign high_freq_clock_req_o = state_reg.hf_run || cal_run_o ||
      (state_reg.lf_run && state_reg.copy.src == SRC_SYNTH);
  assign lf_rc_osc_en_o = state_reg.lf_run && !state_reg.lf_on_xtal &&
      state_reg.copy.src != SRC_SYNTH;
  assign lf_crystal_osc_en_o = state_reg.lf_run &&
      state_reg.copy.src == SRC_XTAL;
  assign lf_crystal_ext_o = lf_crystal_osc_en_o && state_reg.copy.ext;
  assign lf_crystal_bypass_o = lf_crystal_ext_o && state_reg.copy.byp;
  assign lf_synth_source_en_o = state_reg.lf_run &&
      state_reg.copy.src == SRC_SYNTH;
  assign low_freq_clock_mux_o = state_reg.lf_on_xtal ? SRC_XTAL :
      (state_reg.copy.src == SRC_SYNTH ? SRC_SYNTH : SRC_RC);

  // ==========================================================
  // Checks
  logic ev_done_q;
  assign ev_done_q = state_reg.ev[IEN_DONE];

  sequence ct_launch;
    state_reg.ack && cyc_i && stb_i && we_i && addr == OFF_CT_START &&
        trig;
  endsequence
  sequence cal_launch;
    wr && addr == OFF_CAL && trig && state_reg.lf_on &&
        state_reg.copy.src == SRC_RC;
  endsequence

  chk_sel_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> state_reg.sel.src == SRC_RC)
    else $error("source select not RC after reset");
  chk_cal_start: assert property (@(posedge clk_i) disable iff (rst_i)
    cal_launch |=> cal_run_o && high_freq_clock_req_o)
    else $error("calibration did not start");
  chk_cal_done: assert property (@(posedge clk_i) disable iff (rst_i)
    cal_run_o && cal_finish_i |=> ev_done_q && !cal_run_o)
    else $error("calibration complete event missing");
  chk_ct_load: assert property (@(posedge clk_i) disable iff (rst_i)
    ct_launch |=> state_reg.ct == CT_RUN &&
        state_reg.count == $past(state_reg.cal_timer_interval))
    else $error("timer did not load interval");
  chk_ct_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && addr == OFF_CT_STOP && trig |=> state_reg.ct == CT_IDLE)
    else $error("timer did not stop on stop task");
  chk_ct_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg.ct == CT_RUN && lf_tick_i && state_reg.count <= 1 &&
        !wr |=> state_reg.ct == CT_IDLE && state_reg.ev[IEN_CAL_TIMER_TIMEOUT_EVENT])
    else $error("timer did not end at zero");
  chk_snapshot: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && addr == OFF_LF_START && trig |=>
        state_reg.copy == $past(state_reg.sel))
    else $error("snapshot not captured");
  chk_hf_status: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && addr == OFF_HF_START && trig |=> hf_crystal_osc_en_o
        ##1 state_reg.hf_run)
    else $error("hf start not reflected");
  chk_synth_req: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg.lf_run && state_reg.copy.src == SRC_SYNTH |->
        high_freq_clock_req_o && lf_synth_source_en_o)
    else $error("synth source without HF request");
  chk_xtal_switch: assert property (@(posedge clk_i) disable iff (rst_i)
    lf_crystal_osc_en_o && !state_reg.lf_on_xtal |->
        low_freq_clock_mux_o == SRC_RC && lf_rc_osc_en_o)
    else $error("crystal used before running");
  chk_ien_rw: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && addr == OFF_IEN_CLR && sel_i[0] |=>
        (state_reg.ien & $past(dat_i[IEN_W-1:0])) == '0)
    else $error("enable clear ineffective");
endmodule

// ==== sim/testbench.sv ====
/*
  Self-checking bench for the low-frequency clock and calibration
  controller: Wishbone register tasks and directed tests.
  Assumes the design package and one 25 MHz clock domain.
*/
`timescale 1ns/100ps
module testbench;
  import lf_clock_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [ADR_W-1:2] adr_i = '0;
  logic [SEL_W-1:0] sel_i = '0;
  logic [DAT_W-1:0] dat_i = '0;
  logic [DAT_W-1:0] dat_o;
  logic ack_o;
  logic lf_tick_i = 1'b0;
  logic hf_crystal_stable_i = 1'b0;
  logic lf_crystal_running_i = 1'b0;
  logic cal_finish_i = 1'b0;
  logic hf_en, hf_req, rc_en, xt_en, xt_ext, xt_byp, syn_en, cal_run;
  logic [1:0] mux;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] srcv [3] = '{32'h00000001, 32'h00020001, 32'h00030001};

  low_freq_clock_calibration_ctrl uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .lf_tick_i(lf_tick_i),
    .hf_crystal_stable_i(hf_crystal_stable_i),
    .lf_crystal_running_i(lf_crystal_running_i),
    .cal_finish_i(cal_finish_i), .hf_crystal_osc_en_o(hf_en),
    .high_freq_clock_req_o(hf_req), .lf_rc_osc_en_o(rc_en),
    .lf_crystal_osc_en_o(xt_en), .lf_crystal_ext_o(xt_ext),
    .lf_crystal_bypass_o(xt_byp), .lf_synth_source_en_o(syn_en),
    .low_freq_clock_mux_o(mux), .cal_run_o(cal_run)
  );

  always #20 clk_i = ~clk_i;

  // ==========================================================
  // Closing report and hang guard
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("mismatch at %0t: run too long", $time);
      tally_and_finish();
    end
  end

  // ==========================================================
  // Compare tasks
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chkpin(input logic [1:0] got, input logic [1:0] exp,
                        input string msg);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: pin %s got %b exp %b", $time, msg, got,
               exp);
    end
  endtask

  // ==========================================================
  // Bus and timing tasks
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a[11:2];
    dat_i <= d;
    sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input string msg);
    logic [31:0] q;
    wb(1'b0, a, 32'h00000000, q);
    chk32(q, exp, msg);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      lf_tick_i <= 1'b1;
      @(posedge clk_i);
      lf_tick_i <= 1'b0;
      settle();
    end
  endtask

  task automatic reset2();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // ==========================================================
  // Tests
  initial begin
    reset2();
    rd(OFF_LF_SRC, 32'h00000000, "source after reset");
    chkpin(mux, 2'h0, "mux after reset");
    rd(OFF_HF_START, 32'h00000000, "start task read");
    rd(OFF_HF_RUN, 32'h00000000, "hf run idle");
    rd(12'h7FC, 32'h00000000, "unmapped read");
    $display("test reset done");

    wr(OFF_HF_START, 32'h00000001);
    settle();
    chkpin({1'b0, hf_en}, 2'h1, "hf crystal on");
    rd(OFF_HF_RUN, 32'h00000001, "hf run set");
    hf_crystal_stable_i <= 1'b1;
    settle();
    rd(OFF_EV_HF, 32'h00000001, "hf started event");
    $display("test hf start done");

    wr(OFF_LF_START, 32'h00000001);
    settle();
    rd(OFF_LF_RUN, 32'h00000001, "lf run set");
    rd(OFF_LF_COPY, 32'h00000000, "snapshot rc");
    chkpin({rc_en, 1'b0}, 2'h2, "rc on");
    chkpin(mux, 2'h0, "mux rc");
    ticks(1);
    wr(OFF_CAL, 32'h00000001);
    settle();
    chkpin({cal_run, hf_req}, 2'h3, "calibration running");
    chkpin({rc_en, 1'b0}, 2'h2, "rc kept during calibration");
    @(posedge clk_i);
    cal_finish_i <= 1'b1;
    @(posedge clk_i);
    cal_finish_i <= 1'b0;
    settle();
    chkpin({1'b0, cal_run}, 2'h0, "calibration ended");
    rd(OFF_EV_DONE, 32'h00000001, "done event");
    $display("test calibration done");

    wr(OFF_CAL_TIMER_INTERVAL, 32'h00000003);
    ticks(1);
    wr(OFF_CT_START, 32'h00000001);
    ticks(2);
    rd(OFF_EV_CAL_TIMER_TIMEOUT_EVENT, 32'h00000000, "no timeout early");
    ticks(1);
    rd(OFF_EV_CAL_TIMER_TIMEOUT_EVENT, 32'h00000001, "timeout at zero");
    wr(OFF_EV_CAL_TIMER_TIMEOUT_EVENT, 32'h00000000);
    ticks(4);
    rd(OFF_EV_CAL_TIMER_TIMEOUT_EVENT, 32'h00000000, "timer stopped itself");
    wr(OFF_CT_START, 32'h00000001);
    ticks(1);
    wr(OFF_CT_STOP, 32'h00000001);
    ticks(4);
    rd(OFF_EV_CAL_TIMER_TIMEOUT_EVENT, 32'h00000000, "timer halted");
    wr(OFF_CAL_TIMER_INTERVAL, 32'h00000000);
    wr(OFF_CT_START, 32'h00000001);
    ticks(1);
    rd(OFF_EV_CAL_TIMER_TIMEOUT_EVENT, 32'h00000001, "zero interval");
    $display("test timer done");

    for (int i = 0; i < 3; i++) begin
      wr(OFF_LF_STOP, 32'h00000001);
      lf_crystal_running_i <= 1'b0;
      settle();
      wr(OFF_LF_SRC, srcv[i]);
      wr(OFF_LF_START, 32'h00000001);
      settle();
      chkpin({rc_en, mux[0]}, 2'h2, "rc during startup");
      rd(OFF_LF_COPY, srcv[i], "snapshot crystal");
      lf_crystal_running_i <= 1'b1;
      settle();
      chkpin(mux, 2'h1, "mux crystal");
      rd(OFF_LF_STAT, 32'h00010001, "lf status crystal");
      chkpin({1'b0, xt_en}, 2'h1, "crystal on");
      chkpin({xt_ext, xt_byp}, srcv[i][17:16], "swing mode");
    end
    $display("test crystal done");

    wr(OFF_HF_STOP, 32'h00000001);
    wr(OFF_LF_STOP, 32'h00000001);
    settle();
    chkpin({1'b0, hf_req}, 2'h0, "hf idle");
    wr(OFF_LF_SRC, 32'h00000002);
    wr(OFF_LF_START, 32'h00000001);
    settle();
    chkpin(mux, 2'h2, "mux synth");
    chkpin({syn_en, hf_req}, 2'h3, "synth holds hf");
    $display("test synth done");

    wr(OFF_IEN_SET, 32'h0000000F);
    rd(OFF_IEN_SET, 32'h0000000F, "enable set");
    wr(OFF_IEN_CLR, 32'h00000005);
    rd(OFF_IEN_SET, 32'h0000000A, "enable after clear");
    rd(OFF_IEN_CLR, 32'h0000000A, "clear reads state");
    $display("test enables done");

    wr(OFF_CAL_TIMER_INTERVAL, 32'h00000055);
    reset2();
    rd(OFF_CAL_TIMER_INTERVAL, 32'h00000055, "interval retained");
    rd(OFF_LF_SRC, 32'h00000000, "source reset again");
    $display("test retention done");
    tally_and_finish();
  end
endmodule
